// ---- pkg/pbls_pkg.sv ----
/*
 * Package for the power budget level select block: register map, field
 * positions, reset values, budget constants and timing counts.
 * Assumes a 100 MHz system clock and an AXI4-Lite register bus.
 */
package pbls_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_TIME_US = 1;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int RESET_LOW_MIN_US = 16;

	// ----------------------------------------------------------------
	// budget table
	// ----------------------------------------------------------------
	localparam int BUDGET_W = 8;
	localparam int NUM_LEVELS = 16;
	localparam int NUM_BANK_REGS = 8;
	localparam logic [7:0] FIXED_TOP_W = 8'h70;
	localparam logic [7:0] STEP_W = 8'h04;
	localparam logic [7:0] BANK1_RST_W = 8'h8C;
	localparam logic [7:0] BANK0_LOW_RST_W = 8'h90;
	localparam logic [7:0] BANK0_HIGH_RST_W = 8'hB0;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] BANK_REG_BASE = 8'h00;
	localparam logic [7:0] LEVEL_CTRL_OFS = 8'h20;
	localparam logic [7:0] LEVEL_STAT_OFS = 8'h24;

	// level control fields
	localparam int CTRL_HOST_SEL_BIT = 4;
	localparam int CTRL_HIGH_MODE_BIT = 5;
	// level status fields
	localparam int STAT_CODE_LSB = 0;
	localparam int STAT_BUDGET_LSB = 8;
	localparam int STAT_CHANGE_BIT = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [3:0] pbls_code_t;

	// budget output bundle
	typedef struct packed {
		logic [BUDGET_W-1:0] watts;
		pbls_code_t code;
		logic changed;
	} pbls_budget_s;

endpackage : pbls_pkg

// ---- rtl/pbls_pin_filter.sv ----
/*
 * Synchroniser and debouncer for the four level-select pins.
 * Assumes pins are quasi-static board straps that may bounce.
 */
`timescale 1ns/100ps
module pbls_pin_filter #(
	parameter int WIDTH = 4,
	parameter int STABLE_CYCLES = pbls_pkg::DEBOUNCE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] filtered,
	output logic valid
);
	import pbls_pkg::*;

	localparam int CW = $clog2(STABLE_CYCLES + 1);
	localparam logic [CW-1:0] CNT_END = CW'(STABLE_CYCLES);

	logic [WIDTH-1:0] sync1_r;
	logic [WIDTH-1:0] sync2_r;
	logic [WIDTH-1:0] last_r;
	logic [CW-1:0] cnt_r;
	logic valid_r;
	logic [WIDTH-1:0] filtered_r;

	// two-stage synchroniser; first stage feeds nothing but the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	// a word is accepted only after it held still for the whole window,
	// so a multi-pin change never shows an intermediate code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_r <= '0;
			cnt_r <= '0;
			valid_r <= 1'b0;
			filtered_r <= '0;
		end else begin
			last_r <= sync2_r;
			if (sync2_r != last_r) begin
				cnt_r <= '0;
			end else if (cnt_r != CNT_END) begin
				cnt_r <= cnt_r + CW'(1);
			end else begin
				filtered_r <= last_r; // R7
				valid_r <= 1'b1;
			end
		end
	end

	assign filtered = filtered_r;
	assign valid = valid_r;

endmodule : pbls_pin_filter

// ---- rtl/pbls_budget_select.sv ----
/*
 * Total power budget level selector with AXI4-Lite register bank.
 * Assumes board select pins are asynchronous straps, unrelated to SYS_CLK, and a
 * single AXI4-Lite master; the power manager consumes BUDGET_OUT.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps

// What this block does
// R1: four-bit code picks one of sixteen budgets; top half fixed 112 W down to 84 W.
// R2: codes 0 to 7 read writable budget registers, defaults falling 4 W per code.
// R3: a select pin change applies the new budget at once; ports may then shed. Here the change waits for the R7 synchroniser and debounce window.
// R4: level comes from the pins or from a host-written setting.
// R5: external reset must be held low longer than 16 us.
// R6: code 0 register defaults to 144 W in low mode, 176 W in high mode.
// R7: select pins are synchronised and debounced before decoding.
module pbls_budget_select #(
	parameter int DEBOUNCE_CNT = pbls_pkg::DEBOUNCE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic HIGH_POWER_MODE,
	input wire logic LEVEL_SEL_BIT0_PIN,
	input wire logic LEVEL_SEL_BIT1_PIN,
	input wire logic LEVEL_SEL_BIT2_PIN,
	input wire logic LEVEL_SEL_BIT3_BANK_RANGE_PIN,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output pbls_pkg::pbls_budget_s BUDGET_OUT
);
	import pbls_pkg::*;

	// ----------------------------------------------------------------
	// pin filtering
	// ----------------------------------------------------------------
	pbls_code_t pin_code;
	logic pin_valid;

	pbls_pin_filter #(
		.WIDTH(4),
		.STABLE_CYCLES(DEBOUNCE_CNT)
	) u_filter (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.pins({LEVEL_SEL_BIT3_BANK_RANGE_PIN, LEVEL_SEL_BIT2_PIN,
			LEVEL_SEL_BIT1_PIN, LEVEL_SEL_BIT0_PIN}),
		.filtered(pin_code),
		.valid(pin_valid)
	);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [BUDGET_W-1:0] bank_r [NUM_BANK_REGS];
	logic [NUM_BANK_REGS-1:0] bank_wr;
	logic [NUM_BANK_REGS-1:0] bank_touched_r;
	logic host_sel_r;
	pbls_code_t host_code_r;
	logic high_mode_r;
	logic mode_seen_r;
	logic change_r;

	// AXI write side state
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic do_write;
	logic ctrl_wr;
	logic wr_hit;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = !aw_full_r && !bvalid_r;
	assign S_AXI_WREADY = !w_full_r && !bvalid_r;
	assign do_write = aw_full_r && w_full_r && !bvalid_r;

	// address and data are captured independently, in either order
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_full_r <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_r <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end else if (do_write) begin
				w_full_r <= 1'b0;
			end
		end
	end

	// write decode: bank registers then control
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANK_REGS; gi++) begin : g_bank_dec
			assign bank_wr[gi] = do_write && w_strb_r[0] &&
				(aw_addr_r == BANK_REG_BASE + 8'(gi * 4));
		end
	endgenerate
	assign ctrl_wr = do_write && w_strb_r[0] && (aw_addr_r == LEVEL_CTRL_OFS);
	always_comb begin
		if (aw_addr_r[7:5] == 3'h0 && aw_addr_r[1:0] == 2'h0) begin
			wr_hit = 1'b1;
		end else if (aw_addr_r == LEVEL_CTRL_OFS || aw_addr_r == LEVEL_STAT_OFS) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// write response; unmapped addresses get SLVERR
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;

	// ----------------------------------------------------------------
	// budget bank registers
	// ----------------------------------------------------------------
	// untouched registers follow the mode default, so the mode strap
	// sampled after reset still governs code 0 until software overrides
	generate
		for (gi = 0; gi < NUM_BANK_REGS; gi++) begin : g_bank
			logic [BUDGET_W-1:0] dflt;
			if (gi == 0) begin : g_b0
				assign dflt = high_mode_r ? BANK0_HIGH_RST_W : BANK0_LOW_RST_W; // R6
			end else begin : g_bn
				assign dflt = BANK1_RST_W - 8'((gi - 1) * 4); // R2
			end
			always_ff @(posedge SYS_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					bank_r[gi] <= '0;
					bank_touched_r[gi] <= 1'b0;
				end else if (bank_wr[gi]) begin
					bank_r[gi] <= w_data_r[BUDGET_W-1:0];
					bank_touched_r[gi] <= 1'b1;
				end else if (!bank_touched_r[gi]) begin
					bank_r[gi] <= dflt;
				end
			end
		end
	endgenerate

	// mode strap caught once, the first clock after reset release
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			high_mode_r <= 1'b0;
			mode_seen_r <= 1'b0;
		end else if (!mode_seen_r) begin
			high_mode_r <= HIGH_POWER_MODE;
			mode_seen_r <= 1'b1;
		end
	end

	// host level override control
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			host_sel_r <= 1'b0;
			host_code_r <= '0;
		end else if (ctrl_wr) begin
			host_sel_r <= w_data_r[CTRL_HOST_SEL_BIT]; // R4
			host_code_r <= w_data_r[3:0];
		end
	end

	// ----------------------------------------------------------------
	// level decode
	// ----------------------------------------------------------------
	pbls_code_t code_nxt;
	logic [BUDGET_W-1:0] watts_nxt;
	pbls_budget_s budget_r;
	logic stat_rd;

	assign code_nxt = host_sel_r ? host_code_r : pin_code; // R4

	// upper half is a fixed ladder; lower half indexes the bank
	always_comb begin
		if (code_nxt[3]) begin
			watts_nxt = FIXED_TOP_W - STEP_W * {5'h00, code_nxt[2:0]}; // R1
		end else begin
			watts_nxt = bank_r[code_nxt[2:0]]; // R2
		end
	end

	// budget follows the code every cycle, so a pin change takes effect as soon
	// as the debounced code updates; the power manager then sheds ports as needed
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			budget_r <= '0;
		end else begin
			budget_r.watts <= watts_nxt; // R3
			budget_r.code <= code_nxt;
			budget_r.changed <= (pin_valid || host_sel_r) && (code_nxt != budget_r.code);
		end
	end
	assign BUDGET_OUT = budget_r;

	// sticky change flag, set wins over read-clear
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			change_r <= 1'b0;
		end else if (budget_r.changed) begin
			change_r <= 1'b1; // R3
		end else if (stat_rd) begin
			change_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	assign S_AXI_ARREADY = !rvalid_r;
	assign stat_rd = S_AXI_ARVALID && !rvalid_r && (S_AXI_ARADDR == LEVEL_STAT_OFS);

	// one read at a time; data registered, valid one cycle after the address
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
			if (S_AXI_ARADDR[7:5] == 3'h0 && S_AXI_ARADDR[1:0] == 2'h0) begin
				rdata_r[BUDGET_W-1:0] <= bank_r[S_AXI_ARADDR[4:2]];
			end else if (S_AXI_ARADDR == LEVEL_CTRL_OFS) begin
				rdata_r[3:0] <= host_code_r;
				rdata_r[CTRL_HOST_SEL_BIT] <= host_sel_r;
				rdata_r[CTRL_HIGH_MODE_BIT] <= high_mode_r;
			end else if (S_AXI_ARADDR == LEVEL_STAT_OFS) begin
				rdata_r[STAT_CODE_LSB +: 4] <= budget_r.code;
				rdata_r[STAT_BUDGET_LSB +: BUDGET_W] <= budget_r.watts;
				rdata_r[STAT_CHANGE_BIT] <= change_r || budget_r.changed;
			end else begin
				rresp_r <= RESP_SLVERR;
			end
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

endmodule : pbls_budget_select

// ---- testbench/pbls_budget_select_properties.sv ----
/* properties of the budget level selector, watched at its ports.
   assumes address and data of a write are taken on the same edge. */
`timescale 1ns/100ps
module pbls_budget_select_properties #(
	parameter int DEBOUNCE_CNT = pbls_pkg::DEBOUNCE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic HIGH_POWER_MODE,
	input wire logic LEVEL_SEL_BIT0_PIN,
	input wire logic LEVEL_SEL_BIT1_PIN,
	input wire logic LEVEL_SEL_BIT2_PIN,
	input wire logic LEVEL_SEL_BIT3_BANK_RANGE_PIN,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input pbls_pkg::pbls_budget_s BUDGET_OUT
);
	import pbls_pkg::*;
	logic host_r, bank_wr_r, wr_hs;
	logic [3:0] hcode_r, pins;
	logic [7:0] stab_r;
	logic [2:0] up_r;
	assign wr_hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	assign pins = {LEVEL_SEL_BIT3_BANK_RANGE_PIN, LEVEL_SEL_BIT2_PIN,
		LEVEL_SEL_BIT1_PIN, LEVEL_SEL_BIT0_PIN};
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	// host setting as written; any bank write ends the defaults checks
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			host_r <= 1'b0;
			hcode_r <= 4'h0;
			bank_wr_r <= 1'b0;
		end else if (wr_hs) begin
			if (S_AXI_AWADDR == LEVEL_CTRL_OFS && S_AXI_WSTRB[0]) begin
				host_r <= S_AXI_WDATA[CTRL_HOST_SEL_BIT];
				hcode_r <= S_AXI_WDATA[3:0];
			end
			if (S_AXI_AWADDR < LEVEL_CTRL_OFS) begin
				bank_wr_r <= 1'b1;
			end
		end
	end
	// cycles the pins have held still, saturating
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			stab_r <= 8'h00;
		end else if (!$stable(pins)) begin
			stab_r <= 8'h00;
		end else if (stab_r != 8'hFF) begin
			stab_r <= stab_r + 8'h01;
		end
	end
	// banks reload after reset, so defaults are judged only once settled
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			up_r <= 3'h0;
		end else if (up_r != 3'h7) begin
			up_r <= up_r + 3'h1;
		end
	end
	// --------------------------------
	// properties
	// --------------------------------
	sequence ctrl_wr_s;
		wr_hs && S_AXI_AWADDR == LEVEL_CTRL_OFS && S_AXI_WSTRB[0];
	endsequence
	sequence pins_own_s;
		(!host_r) [*4];
	endsequence
	fixed_level_a: assert property (
		BUDGET_OUT.code[3] |-> BUDGET_OUT.watts == FIXED_TOP_W - STEP_W * {5'h00, BUDGET_OUT.code[2:0]})
		else $error("fixed budget level wrong");
	bank_default_a: assert property (
		up_r == 3'h7 && !bank_wr_r && !BUDGET_OUT.code[3] && BUDGET_OUT.code != 4'h0
		|-> BUDGET_OUT.watts == BANK0_LOW_RST_W - STEP_W * {4'h0, BUDGET_OUT.code})
		else $error("bank default budget wrong");
	bank0_default_a: assert property (
		up_r == 3'h7 && !bank_wr_r && BUDGET_OUT.code == 4'h0
		|-> BUDGET_OUT.watts == (HIGH_POWER_MODE ? BANK0_HIGH_RST_W : BANK0_LOW_RST_W))
		else $error("first bank default wrong");
	change_pulse_a: assert property (
		BUDGET_OUT.changed |-> (BUDGET_OUT.code != $past(BUDGET_OUT.code)) ##1 !BUDGET_OUT.changed)
		else $error("change pulse wrong");
	pins_follow_a: assert property (
		pins_own_s ##0 stab_r == DEBOUNCE_CNT + 8 |-> BUDGET_OUT.code == pins)
		else $error("budget code does not follow pins");
	debounce_a: assert property (
		pins_own_s ##0 BUDGET_OUT.changed |-> stab_r > DEBOUNCE_CNT)
		else $error("pin change applied before debounce");
	host_level_a: assert property (
		ctrl_wr_s ##0 S_AXI_WDATA[CTRL_HOST_SEL_BIT] |-> ##[1:4] BUDGET_OUT.code == hcode_r)
		else $error("host level not applied");
	pins_ignored_a: assert property (
		host_r [*8] |-> BUDGET_OUT.code == hcode_r)
		else $error("pins not ignored under host select");
endmodule : pbls_budget_select_properties

bind pbls_budget_select pbls_budget_select_properties #(
	.DEBOUNCE_CNT(DEBOUNCE_CNT)
) u_pbls_budget_select_properties (
	.SYS_CLK, .RESET_N, .HIGH_POWER_MODE, .LEVEL_SEL_BIT0_PIN, .LEVEL_SEL_BIT1_PIN,
	.LEVEL_SEL_BIT2_PIN, .LEVEL_SEL_BIT3_BANK_RANGE_PIN, .S_AXI_AWADDR, .S_AXI_AWVALID,
	.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .BUDGET_OUT
);

// ---- testbench/pbls_board_model.sv ----
/* board-side model of the four level-select straps.
   assumes the bench names a code and, on demand, a one-cycle glitch. */
`timescale 1ns/100ps
module pbls_board_model (
	input wire logic clk,
	input wire logic [3:0] want,
	input wire logic glitch,
	output logic [3:0] pins
);
	logic [3:0] pins_r = 4'h0;
	// a glitch shows the inverse code for one cycle, like a bouncing strap
	always @(posedge clk) begin
		pins_r <= glitch ? ~want : want;
	end
	assign pins = pins_r;
endmodule : pbls_board_model

// ---- testbench/pbls_budget_select_bench.sv ----
/* bench for the budget level selector: bus host tasks, strap model,
   random bank values and corner cases; the checker binds itself. */
`timescale 1ns/100ps
module pbls_budget_select_bench;
	import pbls_pkg::*;
	localparam int DB = 4;
	localparam int SETTLE = DB + 8;
	logic clk = 1'b0, rst_n = 1'b0, hi = 1'b0, glitch = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [3:0] want = 4'h5, strb = 4'hF;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [3:0] pins, c, hc;
	logic [7:0] d;
	logic [31:0] rdata;
	logic [7:0] bank_m [8];
	pbls_budget_s bud;
	int error_cnt = 0, tests_run = 0, cyc = 0;

	always #5 clk = ~clk;
	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			close_out();
		end
	end

	pbls_board_model u_pbls_board_model (.clk(clk), .want(want), .glitch(glitch), .pins(pins));
	pbls_budget_select #(.DEBOUNCE_CNT(DB)) u_pbls_budget_select (
		.SYS_CLK(clk), .RESET_N(rst_n), .HIGH_POWER_MODE(hi),
		.LEVEL_SEL_BIT0_PIN(pins[0]), .LEVEL_SEL_BIT1_PIN(pins[1]),
		.LEVEL_SEL_BIT2_PIN(pins[2]), .LEVEL_SEL_BIT3_BANK_RANGE_PIN(pins[3]),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(1'b1), .BUDGET_OUT(bud)
	);

	// --------------------------------
	// expectations and compares
	// --------------------------------
	function automatic logic [7:0] exp_w(input logic [3:0] code);
		return code[3] ? 8'h70 - 8'h04 * {5'h00, code[2:0]} : bank_m[code[2:0]];
	endfunction : exp_w
	task automatic load_defaults();
		foreach (bank_m[i]) bank_m[i] = 8'h90 - 8'h04 * 8'(i);
		bank_m[0] = hi ? 8'hB0 : 8'h90;
	endtask : load_defaults
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chk_bud(input logic [3:0] code);
		chk("budget code", {28'h0, code}, {28'h0, bud.code});
		chk("budget watts", {24'h0, exp_w(code)}, {24'h0, bud.watts});
	endtask : chk_bud
	task automatic set_pins(input logic [3:0] code);
		want <= code;
		repeat (SETTLE) @(posedge clk);
	endtask : set_pins
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk("write resp", {30'h0, er}, {30'h0, bresp});
	endtask : wr
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk(n, e, rdata);
		chk("read resp", {30'h0, er}, {30'h0, rresp});
	endtask : rd_chk
	task automatic close_out();
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		void'($urandom(97603));
		load_defaults();
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (SETTLE) @(posedge clk);
		chk_bud(4'h5);
		// first debounced code sets the sticky change bit; reading it clears it
		rd_chk("status", LEVEL_STAT_OFS, {15'h0, 1'b1, exp_w(4'h5), 8'h05}, RESP_OKAY);
		rd_chk("status again", LEVEL_STAT_OFS, {15'h0, 1'b0, exp_w(4'h5), 8'h05}, RESP_OKAY);
		for (int i = 0; i < 8; i++) rd_chk("bank", 8'(4 * i), {24'h0, bank_m[i]}, RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			set_pins(4'(i));
			chk_bud(4'(i));
		end
		// a one-cycle bounce must not reach the budget
		glitch <= 1'b1;
		@(posedge clk);
		glitch <= 1'b0;
		repeat (SETTLE) @(posedge clk);
		chk_bud(4'hF);
		repeat (6) begin
			c = 4'($urandom_range(7));
			d = 8'($urandom_range(255));
			set_pins(c);
			wr(8'(4 * c), {24'h0, d}, RESP_OKAY);
			bank_m[c] = d;
			repeat (3) @(posedge clk);
			chk_bud(c);
			rd_chk("bank back", 8'(4 * c), {24'h0, d}, RESP_OKAY);
		end
		// byte lane off, then unmapped place
		strb <= 4'h0;
		wr(8'(4 * c), {24'h0, ~d}, RESP_OKAY);
		strb <= 4'hF;
		rd_chk("masked bank", 8'(4 * c), {24'h0, d}, RESP_OKAY);
		wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
		rd_chk("unmapped", 8'h40, 32'h0, RESP_SLVERR);
		hc = 4'($urandom_range(15));
		wr(LEVEL_CTRL_OFS, {27'h0, 1'b1, hc}, RESP_OKAY);
		set_pins(~hc);
		chk_bud(hc);
		rd_chk("level ctrl", LEVEL_CTRL_OFS, {26'h0, hi, 1'b1, hc}, RESP_OKAY);
		wr(LEVEL_CTRL_OFS, 32'h0, RESP_OKAY);
		set_pins(~hc);
		chk_bud(~hc);
		// long reset in mid-run, now in the higher mode
		rst_n <= 1'b0;
		hi <= 1'b1;
		repeat (1700) @(posedge clk);
		rst_n <= 1'b1;
		load_defaults();
		set_pins(4'h0);
		chk_bud(4'h0);
		rd_chk("first bank", BANK_REG_BASE, 32'h0000_00B0, RESP_OKAY);
		rd_chk("mode strap", LEVEL_CTRL_OFS, 32'h0000_0020, RESP_OKAY);
		close_out();
	end
endmodule : pbls_budget_select_bench
